// ==== src/dsac_ctrl.sv ====
// apb control and status logic of the delta-sigma converter
`timescale 1ns/1ps
module dsac_ctrl (
    // system
    input wire logic SYS_CLK,
    input wire logic RST,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // modulator side
    output logic CONV_GO,
    output logic CONV_ABORT,
    output logic LINKED_START_SELECT,
    output logic [2:0] AMP_GAIN_FIELD,
    input wire logic CONV_DONE,
    input wire logic [23:0] CONV_DATA,
    // interrupt
    output logic IRQ
);
    logic wr_en, rd_en;
    logic sync_q, repeat_q, dly_en_q, done_q, valid_q, ovr_q;
    logic [2:0] gain_q, imask_q, istat_q;
    logic [15:0] dly_q, cnt_q;
    logic [23:0] res_q;
    logic [31:0] rdata_q;
    logic start_wr, stop_rep, finish, stat_rd, res_rd;
    dsac_pkg::dsac_state_t st_q;
    logic setup_rd, stored_q, ev_rd, active, mode_wr, gain_wr, adj_wr, mask_wr;
    logic [2:0] ev_seen, gain_wd;
    logic [15:0] dly_wd;

    assign wr_en = PSEL && PENABLE && PWRITE;
    assign rd_en = PSEL && PENABLE && !PWRITE;
    // single-cycle access phase keeps the slave simple
    assign PREADY = 1'b1;
    assign PSLVERR = 1'b0;
    assign PRDATA = rdata_q;
    assign start_wr = wr_en && PADDR == dsac_pkg::OFF_START && PWDATA[dsac_pkg::BIT_START];
    assign stop_rep = wr_en && PADDR == dsac_pkg::OFF_MODE && !PWDATA[dsac_pkg::BIT_REPEAT]
        && repeat_q;
    assign stat_rd = rd_en && PADDR == dsac_pkg::OFF_STAT;
    assign res_rd = rd_en && PADDR == dsac_pkg::OFF_RES;
    assign finish = st_q == dsac_pkg::ST_CONV && CONV_DONE && !stop_rep;
    assign LINKED_START_SELECT = sync_q;
    assign AMP_GAIN_FIELD = gain_q;
    assign IRQ = |(istat_q & imask_q);
    assign setup_rd = PSEL && !PENABLE && !PWRITE;
    assign ev_rd = rd_en && PADDR == dsac_pkg::OFF_IMASK;
    // clear only the event bits that this read returned, later events stay
    assign ev_seen = ev_rd ? rdata_q[18:16] : 3'h0;
    assign active = st_q != dsac_pkg::ST_IDLE;
    assign mode_wr = wr_en && PADDR == dsac_pkg::OFF_MODE;
    assign gain_wr = wr_en && PADDR == dsac_pkg::OFF_GAIN;
    assign adj_wr = wr_en && PADDR == dsac_pkg::OFF_ADJ;
    assign mask_wr = wr_en && PADDR == dsac_pkg::OFF_IMASK;
    assign gain_wd = PWDATA[dsac_pkg::GAIN_LSB +: 3];
    assign dly_wd = PWDATA[dsac_pkg::DLY_LSB +: 16];

    // control registers; read-only and unused bits are dropped on write
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            sync_q <= 1'b0;
            repeat_q <= 1'b0;
            gain_q <= dsac_pkg::GAIN_RST;
            dly_q <= dsac_pkg::DLY_RST;
            dly_en_q <= 1'b0;
            imask_q <= 3'h0;
        end else if (wr_en) begin
            case (PADDR)
                dsac_pkg::OFF_MODE: begin
                    sync_q <= PWDATA[dsac_pkg::BIT_SYNC];
                    repeat_q <= PWDATA[dsac_pkg::BIT_REPEAT];
                end
                dsac_pkg::OFF_GAIN: gain_q <= PWDATA[dsac_pkg::GAIN_LSB +: 3];
                dsac_pkg::OFF_ADJ: begin
                    dly_q <= PWDATA[dsac_pkg::DLY_LSB +: 16];
                    dly_en_q <= PWDATA[dsac_pkg::BIT_ADJ];
                end
                dsac_pkg::OFF_IMASK: imask_q <= PWDATA[2:0];
                default: ;
            endcase
        end
    end

    // conversion sequencer
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            st_q <= dsac_pkg::ST_IDLE;
            cnt_q <= 16'h0000;
        end else begin
            case (st_q)
                dsac_pkg::ST_IDLE: begin
                    if (start_wr) begin
                        if (dly_en_q && dly_q != 16'h0000) begin
                            st_q <= dsac_pkg::ST_DELAY;
                            cnt_q <= dly_q - 16'h0001;
                        end else begin
                            st_q <= dsac_pkg::ST_CONV;
                        end
                    end
                end
                dsac_pkg::ST_DELAY: begin
                    if (stop_rep) begin
                        st_q <= dsac_pkg::ST_IDLE;
                    end else if (cnt_q == 16'h0000) begin
                        st_q <= dsac_pkg::ST_CONV;
                    end else begin
                        cnt_q <= cnt_q - 16'h0001;
                    end
                end
                dsac_pkg::ST_CONV: begin
                    if (stop_rep) begin
                        st_q <= dsac_pkg::ST_IDLE;
                    end else if (CONV_DONE && !repeat_q) begin
                        st_q <= dsac_pkg::ST_IDLE;
                    end
                end
                default: st_q <= dsac_pkg::ST_IDLE;
            endcase
        end
    end

    // go pulses on entering conversion; abort on repeat stop
    assign CONV_GO = st_q != dsac_pkg::ST_CONV && !RST &&
        ((st_q == dsac_pkg::ST_IDLE && start_wr && !(dly_en_q && dly_q != 16'h0000)) ||
         (st_q == dsac_pkg::ST_DELAY && cnt_q == 16'h0000 && !stop_rep));
    assign CONV_ABORT = stop_rep && st_q != dsac_pkg::ST_IDLE;

    // read data are taken at setup, so a store after that snapshot must survive
    // the clear at the access edge, or a fresh result would be lost unread
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            stored_q <= 1'b0;
        end else if (setup_rd) begin
            stored_q <= finish;
        end else begin
            stored_q <= stored_q || finish;
        end
    end

    // result and its flags; a store in the reading cycle wins over the clear
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            res_q <= dsac_pkg::RES_RST;
            valid_q <= 1'b0;
            ovr_q <= 1'b0;
        end else if (finish) begin
            res_q <= CONV_DATA;
            valid_q <= 1'b1;
            ovr_q <= (valid_q || ovr_q) && !(res_rd && !stored_q);
        end else if (res_rd && !stored_q) begin
            valid_q <= 1'b0;
            ovr_q <= 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            done_q <= 1'b0;
        end else if (finish) begin
            done_q <= 1'b1;
        end else if (stat_rd && !stored_q) begin
            done_q <= 1'b0;
        end
    end

    // sticky events: 0 end, 1 overrun, 2 abort; cleared by reading them
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            istat_q <= 3'h0;
        end else begin
            istat_q <= (istat_q & ~ev_seen) |
                {CONV_ABORT, finish && valid_q && !(res_rd && !stored_q), finish};
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            rdata_q <= dsac_pkg::ZERO_WORD;
        end else if (setup_rd) begin
            case (PADDR)
                dsac_pkg::OFF_MODE: rdata_q <= {23'h0, sync_q, 7'h0, repeat_q};
                dsac_pkg::OFF_GAIN: rdata_q <= {29'h0, gain_q};
                dsac_pkg::OFF_ADJ: rdata_q <= {dly_q, 15'h0, dly_en_q};
                dsac_pkg::OFF_STAT: rdata_q <= {30'h0, done_q, st_q != dsac_pkg::ST_IDLE};
                dsac_pkg::OFF_RES: rdata_q <= {res_q, 6'h0, ovr_q, valid_q};
                dsac_pkg::OFF_IMASK: rdata_q <= {13'h0, istat_q, 13'h0, imask_q};
                default: rdata_q <= dsac_pkg::ZERO_WORD;
            endcase
        end
    end

    done_set_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        finish |=> done_q) else $error("done flag not set");
    done_clr_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        stat_rd && !stored_q && !finish |=> !done_q) else $error("done flag not cleared");
    res_hold_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        !finish |=> $stable(res_q)) else $error("result changed without store");
    res_store_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        finish |=> res_q == $past(CONV_DATA) && valid_q) else $error("store lost");
    ovr_set_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        finish && valid_q && !res_rd |=> ovr_q) else $error("overrun missed");
    res_clr_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        res_rd && !stored_q && !finish |=> !valid_q && !ovr_q) else $error("result flags kept");
    stop_rep_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        stop_rep |=> st_q == dsac_pkg::ST_IDLE) else $error("repeat stop ignored");
    no_irq_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        stop_rep && !istat_q[0] |=> !istat_q[0]) else $error("end event on abort");
    delay_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        st_q == dsac_pkg::ST_IDLE && start_wr && dly_en_q && dly_q == 16'h0003 && !stop_rep
        |=> !CONV_GO [*2] ##1 CONV_GO) else $error("delay count wrong");
    busy_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        CONV_GO |=> st_q == dsac_pkg::ST_CONV) else $error("active flag missing");
    repeat_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        st_q == dsac_pkg::ST_CONV && repeat_q && !stop_rep |=> st_q == dsac_pkg::ST_CONV)
        else $error("repeat run ended");

    // register write effects and write protection
    sync_set_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        mode_wr && PWDATA[dsac_pkg::BIT_SYNC] |=>
        LINKED_START_SELECT)
        else $error("linked start not set");
    sync_clr_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        mode_wr && !PWDATA[dsac_pkg::BIT_SYNC] |=>
        !LINKED_START_SELECT)
        else $error("linked start not cleared");
    rep_set_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        mode_wr && PWDATA[dsac_pkg::BIT_REPEAT] |=>
        repeat_q)
        else $error("repeat mode not set");
    rep_clr_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        mode_wr && !PWDATA[dsac_pkg::BIT_REPEAT] |=>
        !repeat_q)
        else $error("repeat mode not cleared");
    mode_hold_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        !mode_wr |=>
        $stable(sync_q) && $stable(repeat_q))
        else $error("mode bits changed without write");
    gain_wr_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        gain_wr |=>
        AMP_GAIN_FIELD == $past(gain_wd))
        else $error("gain write lost");
    gain_hold_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        !gain_wr |=>
        $stable(gain_q))
        else $error("gain changed without write");
    dly_wr_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        adj_wr |=>
        dly_q == $past(dly_wd))
        else $error("delay write lost");
    dly_en_set_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        adj_wr && PWDATA[dsac_pkg::BIT_ADJ] |=>
        dly_en_q)
        else $error("delay enable not set");
    dly_en_clr_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        adj_wr && !PWDATA[dsac_pkg::BIT_ADJ] |=>
        !dly_en_q)
        else $error("delay enable not cleared");
    adj_hold_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        !adj_wr |=>
        $stable(dly_q) && $stable(dly_en_q))
        else $error("correction changed without write");
    mask_hold_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        !mask_wr |=>
        $stable(imask_q))
        else $error("mask changed without write");

    // read-back of the status, result, start and mode words
    stat_rd_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        setup_rd && PADDR == dsac_pkg::OFF_STAT |=>
        rdata_q[dsac_pkg::BIT_ACTIVE] == $past(active))
        else $error("active flag misread");
    stat_zero_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        setup_rd && PADDR == dsac_pkg::OFF_STAT |=>
        rdata_q[31:2] == 30'h0)
        else $error("status unused bits set");
    res_rd_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        setup_rd && PADDR == dsac_pkg::OFF_RES |=>
        rdata_q[31:8] == $past(res_q))
        else $error("result misread");
    res_zero_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        setup_rd && PADDR == dsac_pkg::OFF_RES |=>
        rdata_q[7:2] == 6'h0)
        else $error("result unused bits set");
    start_zero_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        setup_rd && PADDR == dsac_pkg::OFF_START |=>
        rdata_q == dsac_pkg::ZERO_WORD)
        else $error("start trigger reads nonzero");
    mode_rd_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        setup_rd && PADDR == dsac_pkg::OFF_MODE |=>
        rdata_q[31:9] == 23'h0 && rdata_q[7:1] == 7'h0)
        else $error("mode unused bits set");
    hold_rd_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        !setup_rd |=>
        $stable(rdata_q))
        else $error("read data moved");

    // sequencer: start, delay and the active flag
    nodly_go_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        st_q == dsac_pkg::ST_IDLE && start_wr && !dly_en_q |->
        CONV_GO)
        else $error("undelayed start missing");
    dly_wait_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        st_q == dsac_pkg::ST_IDLE && start_wr && dly_en_q && dly_q != 16'h0000 |->
        !CONV_GO ##1 st_q == dsac_pkg::ST_DELAY)
        else $error("delayed start not delayed");
    go_active_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        st_q == dsac_pkg::ST_IDLE && start_wr |=>
        active)
        else $error("start left flag low");
    single_end_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        st_q == dsac_pkg::ST_CONV && CONV_DONE && !repeat_q && !stop_rep |=>
        !active)
        else $error("single run kept going");
    idle_nogo_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        st_q == dsac_pkg::ST_IDLE && !start_wr |->
        !CONV_GO)
        else $error("start without trigger");
    dly_cnt_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        st_q == dsac_pkg::ST_DELAY && cnt_q != 16'h0000 && !stop_rep |=>
        st_q == dsac_pkg::ST_DELAY && cnt_q == $past(cnt_q) - 16'h0001)
        else $error("delay count skipped");
    rep_go_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        st_q == dsac_pkg::ST_CONV && repeat_q && CONV_DONE && !stop_rep |=>
        active)
        else $error("repeat run dropped flag");

    // events and the interrupt line
    end_ev_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        finish |=>
        istat_q[0])
        else $error("end event missing");
    abort_ev_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        CONV_ABORT |=>
        istat_q[2])
        else $error("abort event missing");
    irq_end_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        finish && imask_q[0] && !mask_wr |=>
        IRQ)
        else $error("end interrupt missing");
    ovr_ev_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        finish && valid_q && !res_rd |=>
        istat_q[1])
        else $error("overrun event missing");
    ev_keep_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        !ev_rd |=>
        (istat_q & $past(istat_q)) == $past(istat_q))
        else $error("event dropped unread");
    irq_low_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        imask_q == 3'h0 |->
        !IRQ)
        else $error("masked interrupt raised");
    abort_done_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        CONV_ABORT |=>
        !done_q || $past(done_q))
        else $error("done set by abort");
    ovr_keep_a: assert property (@(posedge SYS_CLK) disable iff (RST)
        ovr_q && !res_rd |=>
        ovr_q)
        else $error("overrun lost unread");
    cv_single_c: cover property (@(posedge SYS_CLK) finish && !repeat_q);
    cv_repeat_c: cover property (@(posedge SYS_CLK) finish ##[1:50] finish);
    cv_ovr_c: cover property (@(posedge SYS_CLK) ovr_q && res_rd);
    cv_delay_c: cover property (@(posedge SYS_CLK) st_q == dsac_pkg::ST_DELAY && CONV_GO);
    cv_abort_c: cover property (@(posedge SYS_CLK) CONV_ABORT);
endmodule

// ==== src/dsac_pkg.sv ====
// constants and types for the delta-sigma converter control block
// Behaviour
// - linked-start select bit 8, read/write
// - repeat mode bit 0, read/write
// - clearing repeat mode stops conversion itself
// - 3-bit gain field bits 2-0, read/write
// - 16-bit start delay bits 31-16 in clocks
// - delay enable bit 0 inserts delay
// - done flag status bit 1, read clears
// - active flag status bit 0 during start delay and conversion
// - 24-bit two's complement result bits 31-8
// - result holds previous value until stored
// - overrun bit 1 when unread result replaced
// - result-valid bit 0 set on store
// - result read clears overrun and valid
// - start bit begins conversion; end raises interrupt
// - active stays high through repeat run
// - repeat stop abandons conversion, no end interrupt
package dsac_pkg;
    localparam logic [11:0] OFF_START = 12'h008;
    localparam logic [11:0] OFF_MODE = 12'h010;
    localparam logic [11:0] OFF_GAIN = 12'h014;
    localparam logic [11:0] OFF_ADJ = 12'h030;
    localparam logic [11:0] OFF_STAT = 12'h040;
    localparam logic [11:0] OFF_RES = 12'h044;
    localparam logic [11:0] OFF_IMASK = 12'h048;
    localparam int BIT_SYNC = 8;
    localparam int BIT_REPEAT = 0;
    localparam int BIT_START = 0;
    localparam int BIT_ADJ = 0;
    localparam int BIT_ACTIVE = 0;
    localparam int BIT_DONE = 1;
    localparam int BIT_VALID = 0;
    localparam int BIT_OVR = 1;
    localparam int GAIN_LSB = 0;
    localparam int DLY_LSB = 16;
    localparam int RES_LSB = 8;
    localparam logic [2:0] GAIN_RST = 3'h0;
    localparam logic [15:0] DLY_RST = 16'h0000;
    localparam logic [23:0] RES_RST = 24'h000000;
    localparam logic [31:0] ZERO_WORD = 32'h00000000;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_DELAY = 2'b01,
        ST_CONV = 2'b10
    } dsac_state_t;
endpackage

// ==== sim/dsac_mod_model.sv ====
// behavioural modulator and decimator answering conversion requests
`timescale 1ns/1ps
module dsac_mod_model #(parameter int LAT = 40) (
    // control
    input wire logic clk,
    input wire logic rst,
    input wire logic go,
    input wire logic abort,
    input wire logic cont,
    // result
    input wire logic [23:0] data_in,
    output logic done,
    output logic [23:0] data_out
);
    int cnt;
    logic busy;
    logic fin;
    assign fin = busy && cnt == 1 && !go && !abort && !rst;
    always_ff @(posedge clk) begin
        done <= fin;
        // data only stands in the done cycle, so a late sample shows garbage
        data_out <= rst ? 24'h5a5a5a : (fin ? data_in : ~data_out);
        if (rst || abort) begin
            busy <= 1'b0;
        end else if (go || fin) begin
            busy <= go || cont;
            cnt <= LAT;
        end else if (busy) begin
            cnt <= cnt - 1;
        end
    end
endmodule

// ==== sim/testbench.sv ====
// self-checking bench of the converter control block
`timescale 1ns/1ps
module testbench;
    logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, cont = 0;
    logic done, go, ab, irq, lnk, prdy;
    logic [11:0] pa = 12'h000;
    logic [31:0] pwd = 32'h0, prd, rd, sd = 32'he4ea;
    logic [23:0] cd, md = 24'h0, last = 24'h0;
    logic [2:0] gain;
    logic vld = 0, ovr = 0;
    int errors = 0, checks = 0, cyc = 0, acc = 0, goc = 0, st = 0;
    logic [11:0] offs [8] = '{dsac_pkg::OFF_START, dsac_pkg::OFF_MODE, dsac_pkg::OFF_GAIN,
        dsac_pkg::OFF_ADJ, dsac_pkg::OFF_STAT, dsac_pkg::OFF_RES, dsac_pkg::OFF_IMASK, 12'h0fc};
    logic [31:0] wexp [8] = '{32'h0, 32'h101, 32'h7, 32'hffff0001, 32'h0, 32'h0, 32'h7, 32'h0};
    dsac_ctrl dsac_ctrl_inst(.SYS_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
        .PADDR(pa), .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(), .CONV_GO(go),
        .CONV_ABORT(ab), .LINKED_START_SELECT(lnk), .AMP_GAIN_FIELD(gain), .CONV_DONE(done),
        .CONV_DATA(cd), .IRQ(irq));
    dsac_mod_model dsac_mod_model_inst(.clk(clk), .rst(rst), .go(go), .abort(ab), .cont(cont),
        .data_in(md), .done(done), .data_out(cd));
    initial forever #12.5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (go) goc <= cyc;
        if (cyc == 20000) begin
            errors++;
            end_of_test();
        end
    end
    function logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
    endfunction
    task end_of_test;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s exp %h got %h", n, e, g);
        end
    endtask
    // idle edge first, so psel is never reassigned in the step that released it
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1;
        @(posedge clk);
        while (prdy !== 1'b1 && n < 50) begin
            n++;
            @(posedge clk);
        end
        if (n == 50) errors++;
        rd = prd;
        acc = cyc;
        psel <= 0;
        pen <= 0;
    endtask
    task rchk(input logic [11:0] a, input logic [31:0] e, input string n);
        apb(0, a, 32'h0);
        chk(n, e, rd);
    endtask
    task rres;
        rchk(dsac_pkg::OFF_RES, {last, 6'h00, ovr, vld}, "result");
        vld = 0;
        ovr = 0;
    endtask
    task wdone;
        int n;
        n = 0;
        while (done !== 1'b1 && n < 200) begin
            n++;
            @(posedge clk);
        end
        if (n == 200) errors++;
        ovr = vld;
        vld = 1;
        last = md;
    endtask
    task conv(input logic [15:0] dly, input logic en, input logic peek);
        sd = lfsr(sd);
        md <= sd[23:0];
        apb(1, dsac_pkg::OFF_ADJ, {dly, 15'h0000, en});
        apb(1, dsac_pkg::OFF_START, 32'h1);
        st = acc;
        if (peek) rres();
        rchk(dsac_pkg::OFF_STAT, 32'h1, "active");
        wdone();
        chk("go delay", en ? 32'(dly) : 32'h0, 32'(goc - st));
        rchk(dsac_pkg::OFF_STAT, 32'h2, "done");
        rchk(dsac_pkg::OFF_STAT, 32'h0, "done clear");
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst <= 0;
        foreach (offs[i]) rchk(offs[i], 32'h0, "reset");
        for (int i = 1; i < 8; i++) begin
            apb(1, offs[i], 32'hffffffff);
            rchk(offs[i], wexp[i], "access");
        end
        chk("linked", 32'h1, {31'h0, lnk});
        for (int g = 0; g < 5; g++) begin
            apb(1, dsac_pkg::OFF_GAIN, 32'(g));
            @(posedge clk);
            chk("gain", 32'(g), {29'h0, gain});
        end
        apb(1, dsac_pkg::OFF_MODE, 32'h0);
        $display("registers test end");
        conv(7, 0, 0);
        chk("irq", 32'h1, {31'h0, irq});
        rres();
        rchk(dsac_pkg::OFF_IMASK, 32'h00010007, "events");
        @(posedge clk);
        chk("irq clear", 32'h0, {31'h0, irq});
        conv(3, 1, 1);
        conv(0, 1, 0);
        rres();
        rchk(dsac_pkg::OFF_IMASK, 32'h00030007, "events");
        $display("single test end");
        cont <= 1;
        apb(1, dsac_pkg::OFF_MODE, 32'h1);
        apb(1, dsac_pkg::OFF_START, 32'h1);
        wdone();
        rchk(dsac_pkg::OFF_STAT, 32'h3, "repeat active");
        rchk(dsac_pkg::OFF_IMASK, 32'h00010007, "events");
        apb(1, dsac_pkg::OFF_IMASK, 32'h3);
        apb(1, dsac_pkg::OFF_MODE, 32'h0);
        cont <= 0;
        rchk(dsac_pkg::OFF_STAT, 32'h0, "stopped");
        chk("irq masked", 32'h0, {31'h0, irq});
        rres();
        rchk(dsac_pkg::OFF_IMASK, 32'h00040003, "events");
        $display("repeat test end");
        end_of_test();
    end
endmodule
